// ==== verilog/usb_irq_consts.svh ====
// Register offsets, field positions, reset values and timing counts of the USB interrupt block.
`ifndef USB_IRQ_CONSTS_SVH
`define USB_IRQ_CONSTS_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses on the APB).
// ----------------------------------------------------------------
`define OFS_IRQ_ENABLE 8'h00
`define OFS_IRQ_DISABLE 8'h04
`define OFS_IRQ_MASK 8'h08
`define OFS_IRQ_STATUS 8'h0C
`define OFS_IRQ_CLEAR 8'h10
`define OFS_EP_FIFO_RESET 8'h14
`define OFS_EP_CSR0 8'h20

// ----------------------------------------------------------------
// Interrupt bit positions and reset values.
// ----------------------------------------------------------------
`define BIT_SUSPEND 8
`define BIT_RESUME 9
`define BIT_FRAME_START 11
`define BIT_BUS_RESET_DONE 12
`define BIT_WAKEUP 13
`define MASK_RESET 14'h0200
`define MASK_FIXED 14'h1000
`define MASK_VALID 14'h2B0F
`define CLEAR_VALID 14'h3B00
`define STATUS_RESET 14'h0000
`define EP_RESET_RESET 4'h0

// ----------------------------------------------------------------
// Endpoint control/status fields.
// ----------------------------------------------------------------
`define CSR_TRANSMIT_COMPLETE 0
`define CSR_BANK0 1
`define CSR_SETUP 2
`define CSR_STALL 3
`define CSR_TXPKT 4
`define CSR_FSTALL 5
`define CSR_BANK1 6
`define CSR_DIR 7
`define CSR_TYPE_LO 8
`define CSR_TOGGLE 11
`define CSR_ENABLE 15
`define CSR_COUNT_LO 16

// ----------------------------------------------------------------
// Endpoint count.
// ----------------------------------------------------------------
`define NUM_EP 4

// ----------------------------------------------------------------
// Timing: bus idle time before suspend.
// ----------------------------------------------------------------
`define SUSP_IDLE_US 3000
`define PCLK_MHZ 40
`define SUSP_IDLE_CYCLES (`SUSP_IDLE_US * `PCLK_MHZ)

`endif

// ==== verilog/usb_irq_pkg.sv ====
// Types shared by the USB interrupt and endpoint reset logic.
package usb_irq_pkg;

  // Bus idle watch; LIVE, QUIET, SUSP step one bit at a time, except SUSP back to LIVE, which changes both bits.
  typedef enum logic [1:0] {
    LINK_LIVE = 2'b00,
    LINK_QUIET = 2'b01,
    LINK_SUSP = 2'b11
  } link_state_t;

  typedef struct packed {
    logic transmit_complete;
    logic bank0;
    logic setup;
    logic stall;
    logic txpkt;
    logic fstall;
    logic bank1;
    logic dir;
    logic [2:0] ep_kind;
    logic toggle;
    logic enable;
    logic [10:0] count;
  } ep_state_t;

  typedef struct packed {
    link_state_t link;
    logic [16:0] idle;
    logic [13:0] mask;
    logic [13:0] status;
    logic [3:0] fifo_rst;
    logic [31:0] rdata;
  } irq_state_t;

endpackage

// ==== verilog/usb_ep_if.sv ====
// Signals between the interrupt block and one endpoint's control/status logic.
`timescale 1ns/1ps
interface usb_ep_if;
  logic wr;
  logic [31:0] wdata;
  logic fifo_rst;
  logic ev_setup;
  logic ev_bank0;
  logic ev_bank1;
  logic ev_transmit_complete;
  logic ev_stall;
  logic ev_byte;
  logic ev_toggle;
  logic [31:0] rdata;
  logic irq;
  logic toggle;
  modport ctl (output wr, wdata, fifo_rst, ev_setup, ev_bank0, ev_bank1, ev_transmit_complete,
    ev_stall, ev_byte, ev_toggle, input rdata, irq, toggle);
  modport ep (input wr, wdata, fifo_rst, ev_setup, ev_bank0, ev_bank1, ev_transmit_complete,
    ev_stall, ev_byte, ev_toggle, output rdata, irq, toggle);
endinterface

// ==== verilog/usb_ep_csr.sv ====
// One endpoint's control/status register, byte count and data toggle.
`timescale 1ns/1ps
`include "usb_irq_consts.svh"
module usb_ep_csr (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Link to the interrupt block.
  usb_ep_if.ep epi
);
  import usb_irq_pkg::*;

  usb_irq_pkg::ep_state_t s;
  usb_irq_pkg::ep_state_t next_s;

  // Software writes first, device events after, so a flag set in the
  // same cycle as a clearing write survives.
  always_comb begin
    next_s = s;
    if (epi.wr) begin
      next_s.transmit_complete = s.transmit_complete & epi.wdata[`CSR_TRANSMIT_COMPLETE]; // RULE_05
      next_s.bank0 = s.bank0 & epi.wdata[`CSR_BANK0];
      next_s.setup = s.setup & epi.wdata[`CSR_SETUP];
      next_s.stall = s.stall & epi.wdata[`CSR_STALL];
      next_s.bank1 = s.bank1 & epi.wdata[`CSR_BANK1];
      next_s.txpkt = s.txpkt | epi.wdata[`CSR_TXPKT];
      next_s.fstall = epi.wdata[`CSR_FSTALL];
      next_s.dir = epi.wdata[`CSR_DIR];
      next_s.ep_kind = epi.wdata[`CSR_TYPE_LO +: 3];
      next_s.enable = epi.wdata[`CSR_ENABLE];
    end
    if (epi.ev_setup) next_s.setup = 1'b1;
    if (epi.ev_bank0) next_s.bank0 = 1'b1;
    if (epi.ev_bank1) next_s.bank1 = 1'b1;
    if (epi.ev_stall) next_s.stall = 1'b1;
    if (epi.ev_transmit_complete) begin
      next_s.transmit_complete = 1'b1;
      next_s.txpkt = 1'b0;
    end
    if (epi.ev_byte && s.count != 11'h7FF) next_s.count = s.count + 11'h001;
    if (epi.ev_toggle) next_s.toggle = ~s.toggle;
    // Pointer reset wins over traffic and leaves every flag alone.
    if (epi.fifo_rst) begin
      next_s.count = 11'h000; // RULE_13 RULE_15
      next_s.toggle = 1'b0; // RULE_14
    end
  end

  // State register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) s <= '0;
    else s <= next_s;
  end

  // Read view and the endpoint's interrupt source.
  assign epi.rdata = {5'h00, s.count, s.enable, 3'h0, s.toggle, s.ep_kind, s.dir, s.bank1,
    s.fstall, s.txpkt, s.stall, s.setup, s.bank0, s.transmit_complete};
  assign epi.irq = s.setup | s.bank0 | s.bank1 | s.transmit_complete | s.stall; // RULE_04
  assign epi.toggle = s.toggle;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_ep_flag_irq: assert property (epi.ev_bank1 |=> epi.irq) // RULE_04
    else $error("bank 1 event did not raise the endpoint interrupt");
  chk_flag_stays_set: assert property (s.setup && !epi.wr |=> s.setup) // RULE_05
    else $error("setup flag dropped without a clearing write");
  chk_fifo_count_zero: assert property (epi.fifo_rst |=> epi.rdata[26:16] == 11'h000) // RULE_13
    else $error("byte count not zero under endpoint reset");
  chk_toggle_data0: assert property (epi.fifo_rst |=> !epi.toggle) // RULE_14
    else $error("data toggle not DATA0 after endpoint reset");
  chk_reset_keeps_flag: assert property (epi.fifo_rst && !epi.wr && s.bank0 |=> s.bank0) // RULE_15
    else $error("endpoint reset disturbed a status flag");
  cov_reset_with_data: cover property (s.count != 11'h000 ##1 epi.fifo_rst);
endmodule

// ==== verilog/usb_irq_ctrl.sv ====
// Interrupt mask/status, suspend watch, endpoint reset and APB slave of the USB port.
//
// Local design decisions: register access over APB and the register addresses.
`timescale 1ns/1ps
`include "usb_irq_consts.svh"
// Overview of operation
// (RULE_01) Mask bit 12 always reads one and cannot be disabled.
// (RULE_02) Mask bits 0 to 3 read one when that endpoint interrupt is enabled.
// (RULE_03) The resume mask bit is enabled straight out of reset.
// (RULE_04) Endpoint status rises on setup, bank0, bank1, transmit complete or stall flags.
// (RULE_05) Endpoint status stays until software clears the causing control/status flag.
// (RULE_06) Three milliseconds without bus activity sets suspend status and enters suspend.
// (RULE_07) Resume signalling on the port sets the resume status bit.
// (RULE_08) Software clears resume and wakeup status after reset through the clear register.
// (RULE_09) Every start-of-frame token sets the frame start status bit.
// (RULE_10) End of a bus reset sets its status bit; endpoint 0 ready.
// (RULE_11) Wakeup status records host resume or reset since the last clear.
// (RULE_12) Writing one to a clear register bit clears that status; zero does nothing.
// (RULE_13) Endpoint reset bit held one forces that endpoint's byte count to zero.
// (RULE_14) Endpoint reset also returns the data toggle to DATA0.
// (RULE_15) Software releases endpoint reset; the reset leaves control/status flags untouched.
// (RULE_16) Writing one to an enable bit sets the mask bit; zero does nothing.
// (RULE_17) Writing one to a disable bit clears the mask bit; zero does nothing.
// (RULE_18) Interrupt output is high while any enabled status bit is set.
module usb_irq_ctrl #(
  parameter int unsigned IDLE_CYCLES = `SUSP_IDLE_CYCLES
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Bus events from the USB link.
  input wire logic bus_activity,
  input wire logic resume_seen,
  input wire logic sof_seen,
  input wire logic bus_reset_seen,
  input wire logic bus_reset_done,
  // Per-endpoint events from the USB link.
  input wire logic [3:0] setup_event,
  input wire logic [3:0] bank0_event,
  input wire logic [3:0] bank1_event,
  input wire logic [3:0] transmit_complete_event,
  input wire logic [3:0] stall_event,
  input wire logic [3:0] rx_byte_event,
  input wire logic [3:0] toggle_event,
  // Outputs to the USB link and the processor.
  output logic irq,
  output logic suspended,
  output logic [3:0] endpoint_fifo_reset,
  output logic [3:0] data_toggle
);
  import usb_irq_pkg::*;

  // ----------------------------------------------------------------
  // Decoding helpers.
  // ----------------------------------------------------------------

  // Byte address of an endpoint control/status register.
  function automatic logic [7:0] csr_addr(input int unsigned idx);
    csr_addr = `OFS_EP_CSR0 + 8'(idx * 4);
  endfunction

  // True for any address this slave answers.
  function automatic logic is_mapped(input logic [7:0] a);
    logic hit;
    hit = (a == `OFS_IRQ_ENABLE) || (a == `OFS_IRQ_DISABLE) || (a == `OFS_IRQ_MASK);
    hit = hit || (a == `OFS_IRQ_STATUS) || (a == `OFS_IRQ_CLEAR);
    hit = hit || (a == `OFS_EP_FIFO_RESET);
    for (int unsigned i = 0; i < `NUM_EP; i++) begin
      hit = hit || (a == csr_addr(i));
    end
    is_mapped = hit;
  endfunction

  // ----------------------------------------------------------------
  // State and endpoint links.
  // ----------------------------------------------------------------
  usb_irq_pkg::irq_state_t st;
  usb_irq_pkg::irq_state_t next_st;
  usb_ep_if epl [4] ();
  logic [3:0] ep_irq;
  logic [31:0] ep_rdata [4];
  logic [13:0] status_word;
  logic [13:0] mask_word;
  logic wr_en;
  logic rd_setup;
  logic idle_done;

  assign wr_en = psel & penable & pwrite;
  assign rd_setup = psel & ~penable;
  assign idle_done = (st.idle == 17'(IDLE_CYCLES - 2));

  // Endpoint status is live from the flags, so it is sticky exactly as
  // long as the causing flag stays set.
  assign status_word = {st.status[13:4], ep_irq}; // RULE_04 RULE_05
  assign mask_word = st.mask | `MASK_FIXED; // RULE_01

  // ----------------------------------------------------------------
  // Per-endpoint control/status logic.
  // ----------------------------------------------------------------
  for (genvar g = 0; g < `NUM_EP; g++) begin : g_ep
    assign epl[g].wr = wr_en && (paddr == csr_addr(g));
    assign epl[g].wdata = pwdata;
    assign epl[g].fifo_rst = st.fifo_rst[g]; // RULE_13 RULE_14
    assign epl[g].ev_setup = setup_event[g];
    assign epl[g].ev_bank0 = bank0_event[g];
    assign epl[g].ev_bank1 = bank1_event[g];
    assign epl[g].ev_transmit_complete = transmit_complete_event[g];
    assign epl[g].ev_stall = stall_event[g];
    assign epl[g].ev_byte = rx_byte_event[g];
    assign epl[g].ev_toggle = toggle_event[g];
    assign ep_irq[g] = epl[g].irq;
    assign ep_rdata[g] = epl[g].rdata;
    assign data_toggle[g] = epl[g].toggle;

    usb_ep_csr u_ep (
      .pclk(pclk),
      .presetn(presetn),
      .epi(epl[g].ep)
    );
  end

  // ----------------------------------------------------------------
  // Next-state logic.
  // ----------------------------------------------------------------

  // Mask, status, suspend watch, endpoint reset and read capture.
  always_comb begin
    logic [13:0] ev;
    logic [13:0] clr;
    ev = 14'h0000;
    clr = 14'h0000;
    next_st = st;

    // Suspend watch: idle must last the whole window without a break.
    case (st.link)
      LINK_LIVE: begin
        next_st.idle = 17'h00000;
        if (!bus_activity) next_st.link = LINK_QUIET;
      end
      LINK_QUIET: begin
        if (bus_activity) begin
          next_st.link = LINK_LIVE;
        end else if (idle_done) begin
          next_st.link = LINK_SUSP; // RULE_06
          ev[`BIT_SUSPEND] = 1'b1; // RULE_06
        end else begin
          next_st.idle = st.idle + 17'h00001;
        end
      end
      LINK_SUSP: begin
        if (bus_activity || resume_seen) next_st.link = LINK_LIVE;
      end
      default: next_st.link = LINK_LIVE;
    endcase

    // Bus events.
    ev[`BIT_RESUME] = resume_seen; // RULE_07
    ev[`BIT_FRAME_START] = sof_seen; // RULE_09
    ev[`BIT_BUS_RESET_DONE] = bus_reset_done; // RULE_10
    ev[`BIT_WAKEUP] = resume_seen | bus_reset_seen; // RULE_11

    // Register writes.
    if (wr_en) begin
      case (paddr)
        `OFS_IRQ_ENABLE: next_st.mask = st.mask | (pwdata[13:0] & `MASK_VALID); // RULE_16
        `OFS_IRQ_DISABLE: next_st.mask = st.mask & ~(pwdata[13:0] & `MASK_VALID); // RULE_17
        `OFS_IRQ_CLEAR: clr = pwdata[13:0] & `CLEAR_VALID; // RULE_12
        `OFS_EP_FIFO_RESET: next_st.fifo_rst = pwdata[3:0]; // RULE_15
        default: clr = 14'h0000;
      endcase
    end

    // Set wins over clear; the endpoint bits are never stored here.
    next_st.status = ((st.status & ~clr) | ev) & `CLEAR_VALID; // RULE_12

    // Read data is captured in the setup cycle so the access phase
    // answers from a flip-flop with no wait state.
    if (rd_setup) begin
      case (paddr)
        `OFS_IRQ_MASK: next_st.rdata = {18'h00000, mask_word}; // RULE_01 RULE_02
        `OFS_IRQ_STATUS: next_st.rdata = {18'h00000, status_word};
        `OFS_EP_FIFO_RESET: next_st.rdata = {28'h0000000, st.fifo_rst};
        default: next_st.rdata = 32'h00000000;
      endcase
      for (int unsigned i = 0; i < `NUM_EP; i++) begin
        if (paddr == csr_addr(i)) next_st.rdata = ep_rdata[i];
      end
    end
  end

  // ----------------------------------------------------------------
  // State register.
  // ----------------------------------------------------------------

  // Resume stays enabled out of reset so a host resume is seen even if
  // software powered the port down during suspend.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st.link <= LINK_LIVE;
      st.idle <= 17'h00000;
      st.mask <= `MASK_RESET; // RULE_03
      st.status <= `STATUS_RESET;
      st.fifo_rst <= `EP_RESET_RESET;
      st.rdata <= 32'h00000000;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs.
  // ----------------------------------------------------------------

  // Zero wait states; unmapped addresses answer with an error.
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~is_mapped(paddr);
  assign prdata = st.rdata;
  assign irq = |(status_word & mask_word); // RULE_18
  assign suspended = (st.link == LINK_SUSP);
  assign endpoint_fifo_reset = st.fifo_rst;

  // ----------------------------------------------------------------
  // Checks.
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_mask_fixed_bit: assert property (
    rd_setup && paddr == `OFS_IRQ_MASK |=> prdata[12]) // RULE_01
    else $error("mask bit 12 read as zero");
  chk_mask_ep_read: assert property (
    rd_setup && paddr == `OFS_IRQ_MASK |=> prdata[3:0] == $past(st.mask[3:0])) // RULE_02
    else $error("endpoint mask bits read wrong");
  chk_resume_mask_reset: assert property (
    @(posedge pclk) disable iff (1'b0) !presetn |=> st.mask[`BIT_RESUME]) // RULE_03
    else $error("resume mask not enabled after reset");
  chk_suspend_entry: assert property (
    st.link == LINK_QUIET && idle_done && !bus_activity
    |=> suspended && st.status[`BIT_SUSPEND]) // RULE_06
    else $error("suspend not entered at end of idle window");
  chk_no_early_suspend: assert property (
    $rose(suspended) |-> $past(st.link) == LINK_QUIET && $past(idle_done)) // RULE_06
    else $error("suspend entered before the idle window ended");
  chk_resume_wakeup: assert property (
    resume_seen |=> st.status[`BIT_RESUME] && st.status[`BIT_WAKEUP]) // RULE_07 RULE_11
    else $error("resume did not set resume and wakeup status");
  chk_frame_start_set: assert property (
    sof_seen |=> st.status[`BIT_FRAME_START] ##0 irq == st.mask[`BIT_FRAME_START]
    || (|(status_word & mask_word & ~`CLEAR_VALID)) || (|(st.status & mask_word))) // RULE_09
    else $error("frame start status not raised");
  chk_bus_reset_irq: assert property (
    bus_reset_done |=> st.status[`BIT_BUS_RESET_DONE] && irq) // RULE_10 RULE_01
    else $error("end of bus reset did not interrupt");
  chk_reset_wakeup: assert property (
    bus_reset_seen |=> st.status[`BIT_WAKEUP]) // RULE_11
    else $error("bus reset did not set wakeup status");
  chk_clear_one: assert property (
    wr_en && paddr == `OFS_IRQ_CLEAR && pwdata[`BIT_FRAME_START] && !sof_seen
    |=> !st.status[`BIT_FRAME_START]) // RULE_12
    else $error("clear write left frame start status set");
  chk_clear_zero: assert property (
    wr_en && paddr == `OFS_IRQ_CLEAR && !pwdata[`BIT_SUSPEND] && st.status[`BIT_SUSPEND]
    |=> st.status[`BIT_SUSPEND]) // RULE_12
    else $error("clear write of zero cleared suspend status");
  chk_fifo_reset_hold: assert property (
    wr_en && paddr == `OFS_EP_FIFO_RESET && pwdata[0]
    |=> endpoint_fifo_reset[0] ##1 ep_rdata[0][26:16] == 11'h000) // RULE_13
    else $error("endpoint reset did not empty the byte count");
  chk_enable_sets: assert property (
    wr_en && paddr == `OFS_IRQ_ENABLE && pwdata[1] |=> st.mask[1]) // RULE_16
    else $error("enable write did not set the mask bit");
  chk_disable_clears: assert property (
    wr_en && paddr == `OFS_IRQ_DISABLE && pwdata[`BIT_WAKEUP] |=> !st.mask[`BIT_WAKEUP]) // RULE_17
    else $error("disable write did not clear the mask bit");
  chk_irq_follows: assert property (
    st.status[`BIT_SUSPEND] && st.mask[`BIT_SUSPEND] |-> irq) // RULE_18
    else $error("enabled suspend status without interrupt");
  chk_irq_quiet: assert property (
    status_word == 14'h0000 |-> !irq) // RULE_18
    else $error("interrupt high with no status");

  cov_suspend: cover property (st.link == LINK_QUIET ##1 suspended);
  cov_wake: cover property (suspended ##1 resume_seen ##1 !suspended);
  cov_ep_irq: cover property (ep_irq[0] && st.mask[0] && irq);
  cov_slverr: cover property (pslverr);
endmodule

// ==== test/usb_host_model.sv ====
// Behavioural USB host side: bus activity level and one-cycle link events.
`timescale 1ns/1ps
module usb_host_model (
  // Clock.
  input wire logic pclk,
  // Bus level and events toward the device.
  output logic bus_activity,
  output logic resume_seen,
  output logic sof_seen,
  output logic bus_reset_seen,
  output logic bus_reset_done,
  output logic [3:0] setup_event,
  output logic [3:0] bank0_event,
  output logic [3:0] bank1_event,
  output logic [3:0] transmit_complete_event,
  output logic [3:0] stall_event,
  output logic [3:0] rx_byte_event,
  output logic [3:0] toggle_event
);
  // ----------------------------------------------------------------
  // Event pulses.
  // ----------------------------------------------------------------
  // One slot per event kind; a slot is never left high, so no event is counted twice.
  logic [3:0] ev [0:10] = '{default: 4'h0};
  initial bus_activity = 1'b1;
  assign {resume_seen, sof_seen, bus_reset_seen, bus_reset_done} =
    {ev[0][0], ev[1][0], ev[2][0], ev[3][0]};
  assign {setup_event, bank0_event, bank1_event, transmit_complete_event, stall_event, rx_byte_event,
    toggle_event} = {ev[4], ev[5], ev[6], ev[7], ev[8], ev[9], ev[10]};

  // Raise one event for exactly one cycle; the caller stands just after a rising edge.
  task fire(input int k, input logic [3:0] m);
    ev[k] <= m;
    @(posedge pclk);
    ev[k] <= 4'h0;
    // Let the low level be sampled once before any further pulse.
    @(posedge pclk);
  endtask

  // Keep the bus quiet for a number of edges, then show activity again.
  task idle(input int n);
    bus_activity <= 1'b0;
    repeat (n) @(posedge pclk);
    bus_activity <= 1'b1;
  endtask
endmodule

// ==== test/usb_irq_ctrl_tb.sv ====
// Self-checking bench for the USB interrupt and endpoint reset block.
`timescale 1ns/1ps
`include "usb_irq_consts.svh"
module usb_irq_ctrl_tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, r;
  logic pready, pslverr, bus_activity, resume_seen, sof_seen, bus_reset_seen, bus_reset_done;
  logic [3:0] setup_event, bank0_event, bank1_event, transmit_complete_event, stall_event;
  logic [3:0] rx_byte_event, toggle_event, endpoint_fifo_reset, data_toggle;
  logic irq, suspended;
  logic [32:0] exp_q [$];
  int err_count = 0;
  int total_checks = 0;
  int bitpos [5] = '{2, 1, 6, 0, 3};

  always #12.5 pclk = ~pclk;

  usb_irq_ctrl #(.IDLE_CYCLES(20)) i_usb_irq_ctrl (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .bus_activity, .resume_seen, .sof_seen,
    .bus_reset_seen, .bus_reset_done, .setup_event, .bank0_event, .bank1_event,
    .transmit_complete_event, .stall_event, .rx_byte_event, .toggle_event, .irq, .suspended,
    .endpoint_fifo_reset, .data_toggle);
  usb_host_model i_usb_host_model (.pclk, .bus_activity, .resume_seen, .sof_seen,
    .bus_reset_seen, .bus_reset_done, .setup_event, .bank0_event, .bank1_event,
    .transmit_complete_event, .stall_event, .rx_byte_event, .toggle_event);

  // ----------------------------------------------------------------
  // Bus cycles and comparisons.
  // ----------------------------------------------------------------
  task chk(input logic [32:0] seen, input logic [32:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // The wait on pready is bounded so a dead slave cannot hang the run.
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    psel <= 1'b0;
    penable <= 1'b0;
    // One idle edge, so the next call never reassigns psel in this time step.
    @(posedge pclk);
  endtask

  task rd(input logic [7:0] a, input logic [32:0] e);
    exp_q.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask

  // Pins are looked at mid-cycle, where the edge's updates have landed.
  task pin(input int s, input logic [3:0] e);
    logic [3:0] v;
    @(negedge pclk);
    v = s == 0 ? {3'b0, irq} : s == 1 ? {3'b0, suspended} : s == 2 ? data_toggle :
      endpoint_fifo_reset;
    chk({29'h0, v}, {29'h0, e});
    @(posedge pclk);
  endtask

  // Read results are paired with the oldest note as the access phase completes.
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      if (exp_q.size() > 0) chk({pslverr, prdata}, exp_q.pop_front());
      else chk(33'h0, 33'h1);
    end
  end

  task wrap_up();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // A hang counts as a mismatch; the tests need well under this span.
  initial begin
    #(25 * 4000);
    err_count++;
    wrap_up();
  end

  initial begin
    void'($urandom(19));
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b1, `OFS_IRQ_CLEAR, 32'h3B00);
    rd(`OFS_IRQ_MASK, 33'h1200);
    rd(`OFS_IRQ_STATUS, 33'h0);
    rd(`OFS_EP_FIFO_RESET, 33'h0);
    rd(8'h40, 33'h1_0000_0000);
    $display("test reset values done");
    apb(1'b1, `OFS_IRQ_DISABLE, 32'hFFFFFFFF);
    rd(`OFS_IRQ_MASK, 33'h1000);
    r = $urandom & 32'h2B0F;
    apb(1'b1, `OFS_IRQ_ENABLE, r);
    rd(`OFS_IRQ_MASK, {1'b0, r | 32'h1000});
    apb(1'b1, `OFS_IRQ_ENABLE, 32'h0);
    apb(1'b1, `OFS_IRQ_DISABLE, 32'h0);
    rd(`OFS_IRQ_MASK, {1'b0, r | 32'h1000});
    apb(1'b1, `OFS_IRQ_DISABLE, r);
    rd(`OFS_IRQ_MASK, 33'h1000);
    $display("test mask done");
    i_usb_host_model.fire(1, 4'h1);
    i_usb_host_model.fire(0, 4'h1);
    pin(0, 4'h0);
    rd(`OFS_IRQ_STATUS, 33'h2A00);
    i_usb_host_model.fire(3, 4'h1);
    pin(0, 4'h1);
    apb(1'b1, `OFS_IRQ_CLEAR, 32'h0);
    rd(`OFS_IRQ_STATUS, 33'h3A00);
    apb(1'b1, `OFS_IRQ_CLEAR, 32'h1000);
    pin(0, 4'h0);
    rd(`OFS_IRQ_STATUS, 33'h2A00);
    apb(1'b1, `OFS_IRQ_CLEAR, 32'h3B00);
    i_usb_host_model.fire(2, 4'h1);
    rd(`OFS_IRQ_STATUS, 33'h2000);
    apb(1'b1, `OFS_IRQ_CLEAR, 32'h2000);
    rd(`OFS_IRQ_STATUS, 33'h0);
    $display("test bus events done");
    i_usb_host_model.idle(10);
    rd(`OFS_IRQ_STATUS, 33'h0);
    i_usb_host_model.idle(25);
    pin(1, 4'h1);
    rd(`OFS_IRQ_STATUS, 33'h100);
    apb(1'b1, `OFS_IRQ_CLEAR, 32'h100);
    $display("test suspend done");
    apb(1'b1, `OFS_IRQ_ENABLE, 32'hF);
    for (int e = 0; e < 4; e++) begin
      for (int k = 0; k < 5; k++) begin
        i_usb_host_model.fire(4 + k, 4'h1 << e);
        pin(0, 4'h1);
        rd(`OFS_IRQ_STATUS, 33'h1 << e);
        rd(8'(`OFS_EP_CSR0 + 4 * e), 33'h1 << bitpos[k]);
        apb(1'b1, 8'(`OFS_EP_CSR0 + 4 * e), 32'h0);
        rd(`OFS_IRQ_STATUS, 33'h0);
      end
    end
    $display("test endpoint flags done");
    i_usb_host_model.fire(4, 4'h4);
    repeat (3) i_usb_host_model.fire(9, 4'h4);
    i_usb_host_model.fire(10, 4'h4);
    rd(8'h28, 33'h3_0804);
    apb(1'b1, `OFS_EP_FIFO_RESET, 32'h4);
    pin(3, 4'h4);
    pin(2, 4'h0);
    i_usb_host_model.fire(9, 4'h4);
    rd(8'h28, 33'h4);
    rd(`OFS_EP_FIFO_RESET, 33'h4);
    apb(1'b1, `OFS_EP_FIFO_RESET, 32'h0);
    i_usb_host_model.fire(9, 4'h4);
    rd(8'h28, 33'h1_0004);
    $display("test endpoint reset done");
    wrap_up();
  end
endmodule
